// file: design/csg_status_ctrl.v
// status latches, interrupt output and general control commands
// assumes a byte register port from the serial framer on clk;
// analog status and sclk come from outside and are synchronised here
`timescale 1ns/1ps
`include "csg_defines.vh"

module csg_status_ctrl (
  clk,
  rst,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rdata,
  vcxo_loop_locked_now,
  input_active_now,
  reference_present_now,
  not_holdover_now,
  synth_cal_running,
  bias_cal_done,
  sclk,
  read_bit,
  read_drive,
  serial_bidir_pin_o,
  serial_bidir_pin_oe,
  divider_init_pulse,
  force_loop_reacquire,
  bias_calibrate_start,
  bias_cal_busy,
  irq_out_low
);
  input  wire       clk;
  input  wire       rst;
  input  wire [7:0] reg_addr;
  input  wire [7:0] reg_wdata;
  input  wire       reg_wr;
  output reg  [7:0] reg_rdata;
  input  wire       vcxo_loop_locked_now;
  input  wire [3:0] input_active_now;
  input  wire       reference_present_now;
  input  wire       not_holdover_now;
  input  wire       synth_cal_running;
  input  wire       bias_cal_done;
  input  wire       sclk;
  input  wire       read_bit;
  input  wire       read_drive;
  output wire       serial_bidir_pin_o;
  output wire       serial_bidir_pin_oe;
  output wire       divider_init_pulse;
  output wire       force_loop_reacquire;
  output wire       bias_calibrate_start;
  output wire       bias_cal_busy;
  output wire       irq_out_low;

  // ----------------------------------------------------------------
  // synchronisers for outside inputs (status and sclk)
  // ----------------------------------------------------------------
  wire [`CSG_NSTAT:0] raw_in;
  reg  [`CSG_NSTAT:0] sync1_reg;
  reg  [`CSG_NSTAT:0] sync2_reg;
  reg  [`CSG_NSTAT:0] sync3_reg;
  reg  [`CSG_NSTAT:0] filt_reg;

  assign raw_in = {sclk, vcxo_loop_locked_now, input_active_now, reference_present_now,
                   not_holdover_now, synth_cal_running};

  always @(posedge clk) begin
    if (rst) begin
      // idle levels, so no false fault is latched after reset
      sync1_reg     <= `CSG_RST_SYNC;
      sync2_reg     <= `CSG_RST_SYNC;
      sync3_reg     <= `CSG_RST_SYNC;
      filt_reg      <= `CSG_RST_SYNC;
    end else begin
      sync1_reg     <= raw_in;
      sync2_reg     <= sync1_reg;
      sync3_reg     <= sync2_reg;
      // change counts once stages two and three agree
      filt_reg      <= (sync2_reg & ~(sync2_reg ^ sync3_reg)) | (filt_reg & (sync2_reg ^ sync3_reg));
    end
  end

  wire       lock_f = filt_reg[7];
  wire [3:0] act_f  = filt_reg[6:3];
  wire       ref_f  = filt_reg[2];
  wire       hold_f = filt_reg[1];
  wire       cal_f  = filt_reg[0];
  wire       sclk_f = filt_reg[8];
  // sclk edge seen as soon as stages two and three agree
  wire       sclk_agree = ~(sync2_reg[8] ^ sync3_reg[8]);

  // ----------------------------------------------------------------
  // interrupt enables and read edge select
  // ----------------------------------------------------------------
  reg        ie_lock_reg;
  reg  [3:0] ie_act_reg;
  reg        reference_irq_enable_reg;
  reg        holdover_irq_enable_reg;
  reg        read_edge_select_reg;

  wire wr_ie_a  = reg_wr && (reg_addr == `CSG_ADDR_IE_A);
  wire wr_ie_b  = reg_wr && (reg_addr == `CSG_ADDR_IE_B);
  wire wr_lat_a = reg_wr && (reg_addr == `CSG_ADDR_LATCH_A);
  wire wr_lat_b = reg_wr && (reg_addr == `CSG_ADDR_LATCH_B);
  wire wr_init  = reg_wr && (reg_addr == `CSG_ADDR_DIV_INIT);
  wire wr_reacq = reg_wr && (reg_addr == `CSG_ADDR_REACQ);
  wire wr_bias  = reg_wr && (reg_addr == `CSG_ADDR_BIAS_EDGE);

  always @(posedge clk) begin
    if (rst) begin
      ie_lock_reg              <= `CSG_RST_IE;
      ie_act_reg               <= {4{`CSG_RST_IE}};
      reference_irq_enable_reg <= `CSG_RST_IE;
      holdover_irq_enable_reg  <= `CSG_RST_IE;
      read_edge_select_reg     <= `CSG_RST_EDGE;
    end else begin
      if (wr_ie_a) begin
        ie_lock_reg <= reg_wdata[`CSG_BIT_VCXO_LOCK];
        ie_act_reg  <= reg_wdata[3:0];
      end
      if (wr_ie_b) begin
        reference_irq_enable_reg <= reg_wdata[`CSG_BIT_REF];
        holdover_irq_enable_reg  <= reg_wdata[`CSG_BIT_HOLD];
      end
      if (wr_bias) begin
        read_edge_select_reg <= reg_wdata[`CSG_BIT_EDGE];
      end
    end
  end

  // ----------------------------------------------------------------
  // latched status: lock, inputs 3..0, reference, holdover
  // ----------------------------------------------------------------
  wire [`CSG_NLATCH-1:0] good_vec;
  wire [`CSG_NLATCH-1:0] clr_vec;
  wire [`CSG_NLATCH-1:0] ien_vec;
  wire [`CSG_NLATCH-1:0] lat_vec;
  wire [`CSG_NLATCH-1:0] req_vec;

  assign good_vec = {lock_f, act_f, ref_f, hold_f};
  assign clr_vec  = {wr_lat_a & reg_wdata[`CSG_BIT_VCXO_LOCK], {4{wr_lat_a}} & reg_wdata[3:0],
                     wr_lat_b & reg_wdata[`CSG_BIT_REF],
                     wr_lat_b & reg_wdata[`CSG_BIT_HOLD]};
  assign ien_vec  = {ie_lock_reg, ie_act_reg, reference_irq_enable_reg, holdover_irq_enable_reg};

  genvar gi;
  generate
    for (gi = 0; gi < `CSG_NLATCH; gi = gi + 1) begin : g_latch
      csg_latch_cell u_cell (
        .clk        (clk),
        .rst        (rst),
        .good_now   (good_vec[gi]),
        .clear      (clr_vec[gi]),
        .irq_enable (ien_vec[gi]),
        .latched    (lat_vec[gi]),
        .irq_req    (req_vec[gi])
      );
    end
  endgenerate

  reg irq_low_reg;
  always @(posedge clk) begin
    if (rst) begin
      irq_low_reg <= 1'b1;
    end else begin
      irq_low_reg <= ~(|req_vec);
    end
  end
  assign irq_out_low = irq_low_reg;

  // ----------------------------------------------------------------
  // self-clearing commands and bias busy flag (held until bias_cal_done)
  // ----------------------------------------------------------------
  reg init_reg;
  reg reacq_reg;
  reg bias_start_reg;
  reg bias_busy_reg;

  always @(posedge clk) begin
    if (rst) begin
      init_reg       <= 1'b0;
      reacq_reg      <= 1'b0;
      bias_start_reg <= 1'b0;
      bias_busy_reg  <= 1'b0;
    end else begin
      init_reg       <= wr_init & reg_wdata[`CSG_BIT_CMD];
      reacq_reg      <= wr_reacq & reg_wdata[`CSG_BIT_CMD];
      bias_start_reg <= wr_bias & reg_wdata[`CSG_BIT_CMD] & ~bias_busy_reg;
      if (wr_bias && reg_wdata[`CSG_BIT_CMD]) begin
        bias_busy_reg <= 1'b1;
      end else if (bias_cal_done) begin
        bias_busy_reg <= 1'b0;
      end
    end
  end

  assign divider_init_pulse   = init_reg;
  assign force_loop_reacquire = reacq_reg;
  assign bias_calibrate_start = bias_start_reg;
  assign bias_cal_busy        = bias_busy_reg;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      case (reg_addr)
        `CSG_ADDR_IE_A:      reg_rdata <= {3'h0, ie_lock_reg, ie_act_reg};
        `CSG_ADDR_IE_B:      reg_rdata <= {6'h00, reference_irq_enable_reg, holdover_irq_enable_reg};
        `CSG_ADDR_LATCH_A:   reg_rdata <= {3'h0, lat_vec[6:2]};
        `CSG_ADDR_NOW_A:     reg_rdata <= {3'h0, lock_f, act_f};
        `CSG_ADDR_LATCH_B:   reg_rdata <= {6'h00, lat_vec[1:0]};
        `CSG_ADDR_NOW_B:     reg_rdata <= {5'h00, cal_f, ref_f, hold_f};
        `CSG_ADDR_BIAS_EDGE: reg_rdata <= {7'h00, read_edge_select_reg};
        default:             reg_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read data launch on the selected sclk edge
  // ----------------------------------------------------------------
  reg sdo_reg;
  reg sdo_oe_reg;
  // one cycle ahead of filt_reg, so the pin settles before the opposite edge
  wire launch = sclk_agree & (sync3_reg[8] ^ sclk_f) & ~(sync3_reg[8] ^ read_edge_select_reg);

  always @(posedge clk) begin
    if (rst) begin
      sdo_reg    <= 1'b0;
      sdo_oe_reg <= 1'b0;
    end else begin
      sdo_oe_reg <= read_drive;
      if (launch) begin
        sdo_reg <= read_bit;
      end
    end
  end

  assign serial_bidir_pin_o  = sdo_reg;
  assign serial_bidir_pin_oe = sdo_oe_reg;

endmodule // csg_status_ctrl

// file: inc/csg_defines.vh
// constants for the clock status and general control block
// assumes byte-wide register port fed by the serial framer
`ifndef CSG_DEFINES_VH
`define CSG_DEFINES_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CSG_ADDR_IE_A        8'h68
`define CSG_ADDR_IE_B        8'h69
`define CSG_ADDR_LATCH_A     8'h6c
`define CSG_ADDR_NOW_A       8'h6d
`define CSG_ADDR_LATCH_B     8'h6e
`define CSG_ADDR_NOW_B       8'h6f
`define CSG_ADDR_DIV_INIT    8'h71
`define CSG_ADDR_REACQ       8'h72
`define CSG_ADDR_BIAS_EDGE   8'h73

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CSG_BIT_VCXO_LOCK    4
`define CSG_BIT_REF          1
`define CSG_BIT_HOLD         0
`define CSG_BIT_CAL          2
`define CSG_BIT_CMD          7
`define CSG_BIT_EDGE         0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CSG_RST_IE           1'b0
`define CSG_RST_LATCH        1'b1
`define CSG_RST_EDGE         1'b0
// synchroniser idle: sclk low, status good, cal idle
`define CSG_RST_SYNC         9'h0fe

// ----------------------------------------------------------------
// status vector layout: lock, inputs 3..0, ref, hold, cal
// ----------------------------------------------------------------
`define CSG_NSTAT            8
`define CSG_NLATCH           7
`define CSG_SYNC_DEPTH       3

`endif

// file: design/csg_latch_cell.v
// one sticky-low status latch with its interrupt request
// assumes fault and clear are on the core clock
`timescale 1ns/1ps
`include "csg_defines.vh"

module csg_latch_cell (
  clk,
  rst,
  good_now,
  clear,
  irq_enable,
  latched,
  irq_req
);
  input  wire clk;
  input  wire rst;
  input  wire good_now;
  input  wire clear;
  input  wire irq_enable;
  output wire latched;
  output wire irq_req;

  reg latched_reg;
  reg latched_next;

  always @* begin
    latched_next = latched_reg;
    if (clear) begin
      latched_next = 1'b1;
    end
    // fault beats a clear in the same cycle
    if (!good_now) begin
      latched_next = 1'b0;
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      latched_reg <= `CSG_RST_LATCH;
    end else begin
      latched_reg <= latched_next;
    end
  end

  assign latched = latched_reg;
  // request only while latch low and enabled
  assign irq_req = ~latched_reg & irq_enable;

endmodule // csg_latch_cell

// file: tb/csg_host_model.sv
// serial host model: clocks one byte frame, samples the data pin
// assumes pin already resolved with its pull-up
`timescale 1ns/1ps
module csg_host_model (
  input  wire       go,
  input  wire       edge_sel,
  input  wire       pin,
  output reg        sclk,
  output reg  [7:0] rx
);
  initial begin
    sclk = 1'b0;
    rx = 8'h00;
  end
  // sclk low outside frames, sample on the opposite edge
  always @(posedge go) begin
    // sclk edges fall on core clock falling edges, midway between rising edges
    #12.5;
    repeat (8) begin
      #100 sclk = 1'b1;
      if (!edge_sel) rx = {rx[6:0], pin};
      #100 sclk = 1'b0;
      if (edge_sel) rx = {rx[6:0], pin};
    end
  end
endmodule // csg_host_model

// file: tb/csg_status_ctrl_chk.sv
// port checker for the status and control block
// assumes bind onto csg_status_ctrl, one clock domain
`timescale 1ns/1ps
module csg_status_ctrl_chk (
  input wire       clk,
  input wire       rst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire [7:0] reg_rdata,
  input wire       read_drive,
  input wire       serial_bidir_pin_oe,
  input wire       divider_init_pulse,
  input wire       force_loop_reacquire,
  input wire       bias_calibrate_start,
  input wire       bias_cal_busy,
  input wire       bias_cal_done,
  input wire       irq_out_low
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire cw = reg_wr && reg_wdata[7];
  property p_div; cw && reg_addr == 8'h71 |=> divider_init_pulse; endproperty
  a_div: assert property (p_div) else $error("init pulse missing");
  property p_dnone; !(cw && reg_addr == 8'h71) |=> !divider_init_pulse; endproperty
  a_dnone: assert property (p_dnone) else $error("init pulse without write");
  property p_rlk; cw && reg_addr == 8'h72 |=> force_loop_reacquire ##1 !force_loop_reacquire; endproperty
  a_rlk: assert property (p_rlk) else $error("reacquire pulse wrong");
  property p_bst; cw && reg_addr == 8'h73 && !bias_cal_busy |=> bias_calibrate_start && bias_cal_busy; endproperty
  a_bst: assert property (p_bst) else $error("bias start missing");
  property p_bsup; cw && reg_addr == 8'h73 && bias_cal_busy |=> !bias_calibrate_start; endproperty
  a_bsup: assert property (p_bsup) else $error("bias start while busy");
  property p_bhold; bias_cal_busy && !bias_cal_done |=> bias_cal_busy; endproperty
  a_bhold: assert property (p_bhold) else $error("busy dropped early");
  property p_wo; $past(reg_addr) == 8'h71 || $past(reg_addr) == 8'h72 |-> reg_rdata == 8'h00; endproperty
  a_wo: assert property (p_wo) else $error("command reads nonzero");
  property p_b7; $past(reg_addr) == 8'h73 |-> !reg_rdata[7]; endproperty
  a_b7: assert property (p_b7) else $error("command bit reads one");
  property p_oe; serial_bidir_pin_oe == $past(read_drive); endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  c_irq: cover property ($fell(irq_out_low));
  c_busy: cover property ($fell(bias_cal_busy));
  c_oe: cover property ($rose(serial_bidir_pin_oe));
endmodule // csg_status_ctrl_chk

// file: tb/csg_status_ctrl_bench.sv
// bench for the status and control block with a serial host model
// assumes the design includes csg_defines.vh
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module csg_status_ctrl_bench;
  reg        clk = 0, rst = 1, reg_wr = 0, cal = 0, done = 0, rbit = 0, rdrv = 0, go = 0, edge_sel = 0, q, b;
  reg  [7:0] addr = 0, wdata = 0, v;
  reg  [6:0] g = 7'h7f, lat = 7'h7f, ie;
  reg [31:0] seed = 32'h059c;
  wire [7:0] rdata, rx;
  wire       pin_o, pin_oe, irq_n, busy, sclk;
  wire       pin = pin_oe ? pin_o : 1'b1;
  integer    miscompares = 0, checks_done = 0, i, k;
  always #12.5 clk = ~clk;
  csg_status_ctrl dut (.clk(clk), .rst(rst), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(reg_wr),
    .reg_rdata(rdata), .vcxo_loop_locked_now(g[6]), .input_active_now(g[5:2]), .reference_present_now(g[1]),
    .not_holdover_now(g[0]), .synth_cal_running(cal), .bias_cal_done(done), .sclk(sclk), .read_bit(rbit),
    .read_drive(rdrv), .serial_bidir_pin_o(pin_o), .serial_bidir_pin_oe(pin_oe), .divider_init_pulse(),
    .force_loop_reacquire(), .bias_calibrate_start(), .bias_cal_busy(busy), .irq_out_low(irq_n));
  csg_host_model host (.go(go), .edge_sel(edge_sel), .pin(pin), .sclk(sclk), .rx(rx));
  function [31:0] xs(input [31:0] s);
    xs = s ^ (s << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  endfunction
  task cyc(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    reg_wr <= 1;
    @(posedge clk);
    reg_wr <= 0;
  endtask
  // read plus irq and busy snapshot, settled at negedge
  task rd(input [7:0] a);
    @(posedge clk);
    addr <= a;
    cyc(2);
    @(negedge clk);
    v = rdata;
    q = irq_n;
    b = busy;
    @(posedge clk);
  endtask
  task clr_all;
    wr(8'h6c, 8'h1f);
    wr(8'h6e, 8'h03);
    lat = 7'h7f;
  endtask
  task print_verdict;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #1000000;
    miscompares++;
    print_verdict;
  end
  initial begin
    cyc(6);
    rst <= 0;
    cyc(8);
    rd(8'h6c); `CHK(v, 8'h1f)
    rd(8'h6e); `CHK(v, 8'h03)
    clr_all;
    rd(8'h68); `CHK(v, 8'h00)
    rd(8'h70); `CHK(v, 8'h00)
    rd(8'h73); `CHK(v, 8'h00)
    rd(8'h6e); `CHK(v & 8'h03, 8'h03)
    wr(8'h71, 8'h80);
    wr(8'h72, 8'h80);
    wr(8'h73, 8'h80);
    wr(8'h73, 8'h80);
    rd(8'h71); `CHK(v, 8'h00)
    `CHK(b, 1'b1)
    done <= 1;
    cyc(1);
    done <= 0;
    rd(8'h73); `CHK(b, 1'b0)
    $display("test reset and commands done");
    for (i = 0; i < 8; i++) begin
      seed = xs(seed);
      k = seed % 7;
      ie = seed[14:8];
      wr(8'h68, {3'b0, ie[6:2]});
      wr(8'h69, {6'b0, ie[1:0]});
      g[k] <= 0;
      cal <= seed[20];
      cyc(10);
      rd(8'h6d); `CHK(v & 8'h1f, {3'b0, g[6:2]})
      rd(8'h6f); `CHK(v & 8'h07, {5'b0, cal, g[1:0]})
      g[k] <= 1;
      lat[k] = 0;
      cyc(10);
      rd(8'h6c); `CHK(v & 8'h1f, {3'b0, lat[6:2]})
      rd(8'h6e); `CHK(v & 8'h03, {6'b0, lat[1:0]})
      `CHK(q, ~|(~lat & ie))
      clr_all;
      cyc(4);
      rd(8'h6e); `CHK(v & 8'h03, 8'h03)
      `CHK(q, 1'b1)
    end
    $display("test latches done");
    g[1] <= 0;
    cyc(10);
    wr(8'h6e, 8'h02);
    rd(8'h6e); `CHK(v & 8'h02, 8'h00)
    g[1] <= 1;
    cyc(10);
    clr_all;
    $display("test clear race done");
    for (i = 0; i < 2; i++) begin
      wr(8'h73, i[7:0]);
      rd(8'h73); `CHK(v, i[7:0])
      edge_sel <= i[0];
      rbit <= ~i[0];
      rdrv <= 1;
      cyc(8);
      go <= 1;
      cyc(1);
      go <= 0;
      cyc(80);
      rdrv <= 0;
      // falling launch: first rising sample still sees the idle bit
      `CHK(rx, i[0] ? 8'h00 : 8'h7f)
    end
    $display("test serial edge done");
    print_verdict;
  end
endmodule // csg_status_ctrl_bench
bind csg_status_ctrl csg_status_ctrl_chk u_chk (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rdata(reg_rdata), .read_drive(read_drive), .serial_bidir_pin_oe(serial_bidir_pin_oe),
  .divider_init_pulse(divider_init_pulse), .force_loop_reacquire(force_loop_reacquire),
  .bias_calibrate_start(bias_calibrate_start), .bias_cal_busy(bias_cal_busy), .bias_cal_done(bias_cal_done),
  .irq_out_low(irq_out_low));
